//--- logic/rssd_params.svh
// register offsets, field positions, reset values and counts of the datapath
`ifndef RSSD_PARAMS_SVH
`define RSSD_PARAMS_SVH
`define RSSD_OFF_CMD      12'h000
`define RSSD_OFF_ADDR     12'h004
`define RSSD_OFF_IMM      12'h008
`define RSSD_OFF_WREG     12'h00C
`define RSSD_OFF_FLAGS    12'h010
`define RSSD_OFF_STATUS   12'h014
`define RSSD_OFF_MDATA    12'h018
`define RSSD_CMD_OP_MSB   4
`define RSSD_CMD_OP_LSB   0
`define RSSD_CMD_BIT_MSB  10
`define RSSD_CMD_BIT_LSB  8
`define RSSD_FLAGS_MSB    5
`define RSSD_STAT_BUSY    0
`define RSSD_STAT_SKIP    1
`define RSSD_RST_WREG     8'h00
`define RSSD_RST_FLAGS    6'h00
`define RSSD_RST_IMM      8'h00
`define RSSD_RST_ADDR     8'h00
`define RSSD_SET_BYTE_VAL 8'hFF
`define RSSD_QUIET_CYCLES 2'h2
`endif

//--- logic/rssd_pkg.sv
// types shared by the rotate, subtract and skip datapath
package rssd_pkg;
	// operation codes as written into the command register
	typedef enum logic [4:0] {
		OP_NOP                                   = 5'h00,
		OP_ROTATE_LEFT_TO_WORKING_REG            = 5'h01,
		OP_ROTATE_LEFT_VIA_CARRY                 = 5'h02,
		OP_ROTATE_LEFT_VIA_CARRY_TO_WORKING_REG  = 5'h03,
		OP_ROTATE_RIGHT_IN_PLACE                 = 5'h04,
		OP_ROTATE_RIGHT_TO_WORKING_REG           = 5'h05,
		OP_ROTATE_RIGHT_VIA_CARRY                = 5'h06,
		OP_ROTATE_RIGHT_VIA_CARRY_TO_WORKING_REG = 5'h07,
		OP_MINUS_WITH_BORROW                     = 5'h08,
		OP_MINUS_WITH_BORROW_IMM                 = 5'h09,
		OP_MINUS_WITH_BORROW_TO_MEMORY           = 5'h0A,
		OP_MINUS                                 = 5'h0B,
		OP_DECREMENT_SKIP_IF_ZERO                = 5'h0C,
		OP_DECREMENT_SKIP_IF_ZERO_TO_WORKING_REG = 5'h0D,
		OP_SET_BYTE                              = 5'h0E,
		OP_SET_BIT                               = 5'h0F,
		OP_INCREMENT_SKIP_IF_ZERO                = 5'h10,
		OP_INCREMENT_SKIP_IF_ZERO_TO_WORKING_REG = 5'h11,
		OP_SKIP_IF_BIT_NONZERO                   = 5'h12,
		OP_SKIP_IF_NONZERO                       = 5'h13
	} rssd_op_t;
	// sequencer states, gray along idle, execute, dummy
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_EXEC  = 2'h1,
		ST_DUMMY = 2'h3
	} rssd_state_t;
	// status flags, carry in bit 0
	typedef struct packed {
		logic chained_null_bit;
		logic signed_compare_bit;
		logic signed_range_exceeded_bit;
		logic zero;
		logic half_borrow_bit;
		logic carry;
	} rssd_flags_t;
	// whole state of the core
	typedef struct packed {
		rssd_state_t state;
		rssd_op_t    op;
		logic [2:0]  bitsel;
		logic [7:0]  maddr;
		logic [7:0]  imm;
		logic [7:0]  wreg;
		rssd_flags_t flags;
		logic        last_skip;
		logic [1:0]  quiet;
		logic [31:0] prdata;
		logic        pslverr;
	} rssd_core_st_t;
	// whole state of the memory read port
	typedef struct packed {
		logic [7:0] rdata;
	} rssd_mem_st_t;
endpackage

//--- logic/rssd_mem_if.sv
// carrier between the core and its data memory
`timescale 1ns/10ps
interface rssd_mem_if #(
	parameter int AW = 8
);
	logic [AW-1:0] raddr;  // read address, read every cycle
	logic [7:0]    rdata;  // registered read data
	logic          we;     // write strobe
	logic [AW-1:0] waddr;  // write address
	logic [7:0]    wdata;  // write data
	modport core (output raddr, output we, output waddr, output wdata,
		input rdata);
	modport mem (input raddr, input we, input waddr, input wdata,
		output rdata);
endinterface

//--- logic/rssd_mem.sv
// byte-wide data memory with a registered read port
`timescale 1ns/10ps
module rssd_mem
	import rssd_pkg::*;
#(
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	rssd_mem_if.mem  mif
);
	logic [7:0]   ram [0:(1<<AW)-1];  // data bytes, not reset
	rssd_mem_st_t st_ff;              // read register
	rssd_mem_st_t nxt_st;             // its next value

	// read is synchronous so the array maps onto block ram
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = ram[mif.raddr];
	end

	// read register, frozen with the clock enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// write port; a same-cycle read returns the old byte
	always_ff @(posedge pclk) begin
		if (ce && mif.we) begin
			ram[mif.waddr] <= mif.wdata;
		end
	end

	assign mif.rdata = st_ff.rdata;
endmodule

//--- logic/rssd_core.sv
// rotate, subtract and skip datapath with its apb register file
// Notes on behaviour
// - rotate left into working register, no flags
// - rotate left through carry, back to memory
// - same via carry, result to working register
// - rotate right in place, no flags
// - rotate right into working register, no flags
// - rotate right through carry, back to memory
// - rotate right via carry into working register
// - working minus memory minus inverted carry
// - working minus immediate minus inverted carry
// - borrow subtract result written to memory
// - carry is the inverted borrow
// - subtracts update all six flags
// - decrement memory, skip when zero, no flags
// - decrement into working register, skip when zero
// - a skip adds one dummy cycle
// - set byte writes all ones, no flags
// - set bit touches only that bit
// - increment memory, skip when wrapped to zero
// - increment into working register, skip when zero
// - skip when selected bit is one
// - rewrite byte, skip when nonzero
// - plain subtract, no borrow input
`timescale 1ns/10ps
`include "rssd_params.svh"
module rssd_core
	import rssd_pkg::*;
#(
	parameter int MEM_AW = 8
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             busy,
	output logic             dummy_cycle
);
	localparam rssd_core_st_t CORE_RST = '{
		state: ST_IDLE, op: OP_NOP, bitsel: 3'h0,
		maddr: `RSSD_RST_ADDR, imm: `RSSD_RST_IMM,
		wreg: `RSSD_RST_WREG, flags: `RSSD_RST_FLAGS,
		last_skip: 1'b0, quiet: 2'h0, prdata: 32'h0, pslverr: 1'b0};

	rssd_core_st_t st_ff;     // all core state
	rssd_core_st_t nxt_st;    // its next value
	logic [7:0]    opnd;      // memory operand of the running op
	logic [7:0]    sub_b;     // subtrahend
	logic          sub_bin;   // borrow into the subtraction
	logic [8:0]    diff9;     // full difference, bit 8 is borrow out
	logic [4:0]    half5;     // low nibble difference
	rssd_flags_t   sub_flags; // flags a subtraction would leave
	logic          skip_now;  // the running op skips
	logic          mem_we;    // memory write strobe
	logic [7:0]    mem_wd;    // memory write data
	logic          apb_wr;    // accepted apb write
	logic          idle;      // sequencer is idle
	logic          ex_go;     // execute cycle that will advance

	rssd_mem_if #(.AW(MEM_AW)) mif();

	rssd_mem #(.AW(MEM_AW)) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.mif     (mif)
	);

	assign opnd = mif.rdata;
	assign idle = (st_ff.state == ST_IDLE);
	assign ex_go = ce && (st_ff.state == ST_EXEC);
	// answer only once idle long enough for read data to be fresh
	assign pready = psel && penable && ce && idle &&
		(st_ff.quiet == `RSSD_QUIET_CYCLES);
	assign apb_wr = pready && pwrite;

	// subtrahend: the immediate for its own form, else memory
	assign sub_b = (st_ff.op == OP_MINUS_WITH_BORROW_IMM) ?
		st_ff.imm : opnd;
	// plain subtract takes no borrow, the rest the inverted carry
	assign sub_bin = (st_ff.op == OP_MINUS) ?
		1'b0 : ~st_ff.flags.carry;
	assign diff9 = {1'b0, st_ff.wreg} - {1'b0, sub_b} - {8'h00, sub_bin};
	assign half5 = {1'b0, st_ff.wreg[3:0]} - {1'b0, sub_b[3:0]} -
		{4'h0, sub_bin};

	// flags of a subtraction, carries read as inverted borrows
	always_comb begin
		sub_flags.carry = ~diff9[8];
		sub_flags.half_borrow_bit = ~half5[4];
		sub_flags.zero = (diff9[7:0] == 8'h00);
		sub_flags.signed_range_exceeded_bit =
			(st_ff.wreg[7] != sub_b[7]) &&
			(diff9[7] != st_ff.wreg[7]);
		sub_flags.signed_compare_bit =
			sub_flags.signed_range_exceeded_bit ^ diff9[7];
		// chained forms keep a zero only if the earlier byte was zero
		sub_flags.chained_null_bit = (st_ff.op == OP_MINUS) ?
			sub_flags.zero :
			(sub_flags.zero && st_ff.flags.chained_null_bit);
	end

	// next state: apb side while idle, datapath while executing
	always_comb begin
		nxt_st = st_ff;
		mem_we = 1'b0;
		mem_wd = 8'h00;
		skip_now = 1'b0;
		// register read data and error, captured while selected
		if (psel) begin
			nxt_st.pslverr = 1'b0;
			case (paddr)
				`RSSD_OFF_CMD: nxt_st.prdata = {21'h0, st_ff.bitsel,
					3'h0, st_ff.op};
				`RSSD_OFF_ADDR: nxt_st.prdata = {24'h0, st_ff.maddr};
				`RSSD_OFF_IMM: nxt_st.prdata = {24'h0, st_ff.imm};
				`RSSD_OFF_WREG: nxt_st.prdata = {24'h0, st_ff.wreg};
				`RSSD_OFF_FLAGS: nxt_st.prdata = {26'h0, st_ff.flags};
				`RSSD_OFF_STATUS: nxt_st.prdata = {30'h0,
					st_ff.last_skip, !idle};
				`RSSD_OFF_MDATA: nxt_st.prdata = {24'h0, opnd};
				default: begin
					// unmapped: read zero, flag an error
					nxt_st.prdata = 32'h0;
					nxt_st.pslverr = 1'b1;
				end
			endcase
		end
		// register writes; status is read only
		if (apb_wr) begin
			case (paddr)
				`RSSD_OFF_CMD: begin
					nxt_st.op = rssd_op_t'(
						pwdata[`RSSD_CMD_OP_MSB:`RSSD_CMD_OP_LSB]);
					nxt_st.bitsel =
						pwdata[`RSSD_CMD_BIT_MSB:`RSSD_CMD_BIT_LSB];
					nxt_st.state = ST_EXEC;
				end
				`RSSD_OFF_ADDR: nxt_st.maddr = pwdata[7:0];
				`RSSD_OFF_IMM: nxt_st.imm = pwdata[7:0];
				`RSSD_OFF_WREG: nxt_st.wreg = pwdata[7:0];
				`RSSD_OFF_FLAGS: nxt_st.flags = rssd_flags_t'(
					pwdata[`RSSD_FLAGS_MSB:0]);
				`RSSD_OFF_MDATA: begin
					mem_we = 1'b1;
					mem_wd = pwdata[7:0];
				end
				default: begin
					// ignored; unmapped places already got the error, status writes get none
				end
			endcase
		end
		// sequencer
		case (st_ff.state)
			ST_IDLE: begin
				// nothing running
			end
			ST_EXEC: begin
				case (st_ff.op)
					OP_ROTATE_LEFT_TO_WORKING_REG: begin
						nxt_st.wreg = {opnd[6:0], opnd[7]};
					end
					OP_ROTATE_LEFT_VIA_CARRY: begin
						mem_we = 1'b1;
						mem_wd = {opnd[6:0], st_ff.flags.carry};
						nxt_st.flags.carry = opnd[7];
					end
					OP_ROTATE_LEFT_VIA_CARRY_TO_WORKING_REG: begin
						nxt_st.wreg = {opnd[6:0], st_ff.flags.carry};
						nxt_st.flags.carry = opnd[7];
					end
					OP_ROTATE_RIGHT_IN_PLACE: begin
						mem_we = 1'b1;
						mem_wd = {opnd[0], opnd[7:1]};
					end
					OP_ROTATE_RIGHT_TO_WORKING_REG: begin
						nxt_st.wreg = {opnd[0], opnd[7:1]};
					end
					OP_ROTATE_RIGHT_VIA_CARRY: begin
						mem_we = 1'b1;
						mem_wd = {st_ff.flags.carry, opnd[7:1]};
						nxt_st.flags.carry = opnd[0];
					end
					OP_ROTATE_RIGHT_VIA_CARRY_TO_WORKING_REG: begin
						nxt_st.wreg = {st_ff.flags.carry, opnd[7:1]};
						nxt_st.flags.carry = opnd[0];
					end
					OP_MINUS_WITH_BORROW, OP_MINUS_WITH_BORROW_IMM,
					OP_MINUS: begin
						nxt_st.wreg = diff9[7:0];
						nxt_st.flags = sub_flags;
					end
					OP_MINUS_WITH_BORROW_TO_MEMORY: begin
						mem_we = 1'b1;
						mem_wd = diff9[7:0];
						nxt_st.flags = sub_flags;
					end
					OP_DECREMENT_SKIP_IF_ZERO: begin
						mem_we = 1'b1;
						mem_wd = opnd - 8'h01;
						skip_now = (opnd == 8'h01);
					end
					OP_DECREMENT_SKIP_IF_ZERO_TO_WORKING_REG: begin
						nxt_st.wreg = opnd - 8'h01;
						skip_now = (opnd == 8'h01);
					end
					OP_SET_BYTE: begin
						mem_we = 1'b1;
						mem_wd = `RSSD_SET_BYTE_VAL;
					end
					OP_SET_BIT: begin
						mem_we = 1'b1;
						mem_wd = opnd | (8'h01 << st_ff.bitsel);
					end
					OP_INCREMENT_SKIP_IF_ZERO: begin
						mem_we = 1'b1;
						mem_wd = opnd + 8'h01;
						skip_now = (opnd == 8'hFF);
					end
					OP_INCREMENT_SKIP_IF_ZERO_TO_WORKING_REG: begin
						nxt_st.wreg = opnd + 8'h01;
						skip_now = (opnd == 8'hFF);
					end
					OP_SKIP_IF_BIT_NONZERO: begin
						skip_now = opnd[st_ff.bitsel];
					end
					OP_SKIP_IF_NONZERO: begin
						// the byte goes back unchanged, as a real rewrite
						mem_we = 1'b1;
						mem_wd = opnd;
						skip_now = (opnd != 8'h00);
					end
					default: begin
						// undefined codes act as no operation
					end
				endcase
				nxt_st.last_skip = skip_now;
				// a skip spends one more cycle as a dummy
				nxt_st.state = skip_now ? ST_DUMMY : ST_IDLE;
			end
			ST_DUMMY: begin
				nxt_st.state = ST_IDLE;
			end
			default: begin
				nxt_st.state = ST_IDLE;
			end
		endcase
		// quiet counter restarts on any change to answerable state
		if (!idle || apb_wr) begin
			nxt_st.quiet = 2'h0;
		end else if (st_ff.quiet != `RSSD_QUIET_CYCLES) begin
			nxt_st.quiet = st_ff.quiet + 2'h1;
		end
	end

	// single state register, frozen while the enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= CORE_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// memory port: exec writes go to the operand's own byte
	assign mif.raddr = st_ff.maddr[MEM_AW-1:0];
	assign mif.we = mem_we;
	assign mif.waddr = st_ff.maddr[MEM_AW-1:0];
	assign mif.wdata = mem_wd;

	assign prdata = st_ff.prdata;
	assign pslverr = st_ff.pslverr;
	assign busy = !idle;
	assign dummy_cycle = (st_ff.state == ST_DUMMY);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_skip_taken;
		ex_go && skip_now;
	endsequence
	sequence s_dummy_once;
		dummy_cycle && busy ##1 (!dummy_cycle || !ce);
	endsequence

	property p_rot_left_wreg;
		ex_go && st_ff.op == OP_ROTATE_LEFT_TO_WORKING_REG |=>
			st_ff.wreg == {$past(opnd[6:0]), $past(opnd[7])} &&
			st_ff.flags == $past(st_ff.flags);
	endproperty
	a_rot_left_wreg: assert property (p_rot_left_wreg)
		else $error("rotate left to working register wrong");

	property p_rot_left_carry;
		ex_go && st_ff.op == OP_ROTATE_LEFT_VIA_CARRY |->
			(mem_we && mem_wd == {opnd[6:0], st_ff.flags.carry})
			##1 (st_ff.flags.carry == $past(opnd[7]));
	endproperty
	a_rot_left_carry: assert property (p_rot_left_carry)
		else $error("rotate left through carry wrong");

	property p_rot_right_place;
		ex_go && st_ff.op == OP_ROTATE_RIGHT_IN_PLACE |->
			mem_we && mem_wd == {opnd[0], opnd[7:1]} ##1
			$stable(st_ff.flags) && $stable(st_ff.wreg);
	endproperty
	a_rot_right_place: assert property (p_rot_right_place)
		else $error("rotate right in place wrong");

	property p_rot_right_carry_wreg;
		ex_go && st_ff.op == OP_ROTATE_RIGHT_VIA_CARRY_TO_WORKING_REG
			|-> !mem_we ##1 st_ff.flags.carry == $past(opnd[0]) &&
			st_ff.wreg[7] == $past(st_ff.flags.carry);
	endproperty
	a_rot_right_carry_wreg: assert property (p_rot_right_carry_wreg)
		else $error("rotate right through carry to register wrong");

	property p_sub_flags;
		ex_go && st_ff.op == OP_MINUS |=>
			st_ff.flags.carry == ($past(st_ff.wreg) >= $past(opnd)) &&
			st_ff.flags.zero == (st_ff.wreg == 8'h00);
	endproperty
	a_sub_flags: assert property (p_sub_flags)
		else $error("subtract carry or zero flag wrong");

	property p_borrow_imm;
		ex_go && st_ff.op == OP_MINUS_WITH_BORROW_IMM |=>
			st_ff.wreg == 8'($past(st_ff.wreg) - $past(st_ff.imm) -
			8'(!$past(st_ff.flags.carry)));
	endproperty
	a_borrow_imm: assert property (p_borrow_imm)
		else $error("immediate borrow subtract wrong");

	// skip judged on the byte written back, not on the operand
	property p_dec_skip;
		ex_go && st_ff.op == OP_DECREMENT_SKIP_IF_ZERO |->
			mem_we && 8'(mem_wd + 8'h01) == opnd ##1
			st_ff.last_skip == ($past(mem_wd) == 8'h00) &&
			dummy_cycle == st_ff.last_skip;
	endproperty
	a_dec_skip: assert property (p_dec_skip)
		else $error("decrement and skip wrong");

	property p_inc_skip_wreg;
		ex_go && st_ff.op == OP_INCREMENT_SKIP_IF_ZERO_TO_WORKING_REG |=>
			st_ff.wreg == $past(opnd) + 8'h01 &&
			st_ff.last_skip == (st_ff.wreg == 8'h00);
	endproperty
	a_inc_skip_wreg: assert property (p_inc_skip_wreg)
		else $error("increment and skip to register wrong");

	// the dummy cycle itself must follow the tested bit
	property p_bit_skip;
		ex_go && st_ff.op == OP_SKIP_IF_BIT_NONZERO |->
			!mem_we ##1 dummy_cycle ==
			$past((opnd & (8'h01 << st_ff.bitsel)) != 8'h00);
	endproperty
	a_bit_skip: assert property (p_bit_skip)
		else $error("bit test skip wrong");

	property p_skip_dummy;
		s_skip_taken |=> s_dummy_once;
	endproperty
	a_skip_dummy: assert property (p_skip_dummy)
		else $error("skip did not insert exactly one dummy cycle");

	property p_no_skip_no_dummy;
		ex_go && !skip_now |=> !busy;
	endproperty
	a_no_skip_no_dummy: assert property (p_no_skip_no_dummy)
		else $error("dummy cycle without a skip");

	property p_set_bit;
		ex_go && st_ff.op == OP_SET_BIT |->
			mem_we && mem_wd[st_ff.bitsel] &&
			(mem_wd & ~(8'h01 << st_ff.bitsel)) ==
			(opnd & ~(8'h01 << st_ff.bitsel));
	endproperty
	a_set_bit: assert property (p_set_bit)
		else $error("set bit touched other bits");
endmodule

//--- tb/rssd_host_model.sv
// apb master standing in for the decoder side of the datapath
`timescale 1ns/10ps
module rssd_host_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// one transfer, request held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// wait states come from the slave, no fixed count
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data must not keep showing the old word
		pwdata <= ~d;
	endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the rotate, subtract and skip datapath
`timescale 1ns/10ps
`include "rssd_params.svh"
module tb_top
	import rssd_pkg::*;
;
	logic        pclk;        // 200 MHz bench clock
	logic        presetn;     // async reset, low active
	logic        ce;          // clock enable
	wire  logic  psel, penable, pwrite, pready, pslverr;
	wire  logic  busy, dummy_cycle;
	wire  logic [11:0] paddr;
	wire  logic [31:0] pwdata, prdata;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc = 0;     // timeout counter
	logic [31:0] rv;          // last read word
	logic        er;          // last error response
	// cases: {op, bit, mem byte, wreg, imm, flags}
	localparam int NC = 29;
	logic [47:0] cases [0:NC-1] = '{
		48'h01_00_81_00_00_00, 48'h02_00_80_00_00_00, 48'h02_00_01_00_00_01,
		48'h03_00_80_00_00_01, 48'h04_00_01_00_00_00, 48'h05_00_02_00_00_3F,
		48'h06_00_01_00_00_00, 48'h07_00_80_00_00_01, 48'h08_00_10_10_00_00,
		48'h08_00_0F_10_00_01, 48'h09_00_55_80_01_01, 48'h0A_00_05_05_00_21,
		48'h0B_00_01_00_00_3E, 48'h0B_00_03_03_00_00, 48'h0C_00_01_00_00_00,
		48'h0C_00_00_00_00_00, 48'h0D_00_01_77_00_00, 48'h0D_00_05_00_00_00,
		48'h0E_00_12_00_00_3F, 48'h0F_07_00_00_00_00, 48'h0F_00_FE_00_00_00,
		48'h10_00_FF_00_00_00, 48'h11_00_FE_00_00_00, 48'h11_00_FF_00_00_00,
		48'h12_03_08_00_00_00, 48'h12_03_F7_00_00_00, 48'h13_00_00_00_00_00,
		48'h13_00_40_00_00_00, 48'h1F_00_33_44_00_3F};

	rssd_core dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
		.dummy_cycle(dummy_cycle));
	rssd_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// prints the counts and the verdict, then stops
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, far above the thousand or so cycles needed
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rv, er);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ex,
		input string nm);
		host.xfer(1'b0, a, 32'h00000000, rv, er);
		chk(nm, ex, rv);
	endtask

	// expected {skip, flags, mem byte, wreg} worked out independently
	function automatic logic [31:0] model(input logic [47:0] c);
		logic [7:0] op, m, w, s, res;
		logic [5:0] f;
		logic [8:0] full;
		logic [4:0] nib;
		logic       sk, b, ov;
		op = c[47:40];
		m = c[31:24];
		w = c[23:16];
		f = c[5:0];
		s = (op == 8'h09) ? c[15:8] : m;
		b = (op == 8'h0B) ? 1'b0 : ~f[0];
		full = {1'b0, w} - {1'b0, s} - {8'h00, b};
		nib = {1'b0, w[3:0]} - {1'b0, s[3:0]} - {4'h0, b};
		res = full[7:0];
		ov = (w[7] ^ s[7]) & (res[7] ^ w[7]);
		sk = 1'b0;
		case (op)
		8'h01: w = {m[6:0], m[7]};
		8'h02: {f[0], m} = {m, f[0]};
		8'h03: {f[0], w} = {m, f[0]};
		8'h04: m = {m[0], m[7:1]};
		8'h05: w = {m[0], m[7:1]};
		8'h06: {m, f[0]} = {f[0], m};
		8'h07: {w, f[0]} = {f[0], m};
		8'h08, 8'h09, 8'h0A, 8'h0B: begin
			if (op == 8'h0A)
				m = res;
			else
				w = res;
			f = {(op == 8'h0B) ? res == 0 : (res == 0) & f[5],
				ov ^ res[7], ov, res == 0, ~nib[4], ~full[8]};
		end
		8'h0C: begin
			m = m - 8'h01;
			sk = m == 0;
		end
		8'h0D: begin
			w = m - 8'h01;
			sk = w == 0;
		end
		8'h0E: m = 8'hFF;
		8'h0F: m[c[34:32]] = 1'b1;
		8'h10: begin
			m = m + 8'h01;
			sk = m == 0;
		end
		8'h11: begin
			w = m + 8'h01;
			sk = w == 0;
		end
		8'h12: sk = m[c[34:32]];
		8'h13: sk = m != 0;
		default: ;
		endcase
		return {7'h00, sk, 2'h0, f, m, w};
	endfunction

	// load operands, run one command, check every visible result
	task automatic run_case(input int i);
		logic [31:0] ex;
		int          nb;
		logic        sd;
		ex = model(cases[i]);
		nb = 0;
		sd = 1'b0;
		wr(`RSSD_OFF_ADDR, 32'(i * 7));
		wr(`RSSD_OFF_MDATA, {24'h000000, cases[i][31:24]});
		wr(`RSSD_OFF_WREG, {24'h000000, cases[i][23:16]});
		wr(`RSSD_OFF_IMM, {24'h000000, cases[i][15:8]});
		wr(`RSSD_OFF_FLAGS, {26'h0000000, cases[i][5:0]});
		wr(`RSSD_OFF_CMD, {21'h000000, cases[i][34:32], 3'h0,
			cases[i][44:40]});
		// count busy cycles after the accepting edge
		repeat (4) begin
			@(posedge pclk);
			nb += int'(busy === 1'b1);
			sd |= (dummy_cycle === 1'b1);
		end
		chk("busy cycles", 32'(1 + ex[24]), 32'(nb));
		chk("dummy cycle", {31'h0, ex[24]}, {31'h0, sd});
		rd(`RSSD_OFF_WREG, {24'h0, ex[7:0]}, "wreg");
		rd(`RSSD_OFF_MDATA, {24'h0, ex[15:8]}, "memory byte");
		rd(`RSSD_OFF_FLAGS, {26'h0, ex[21:16]}, "flags");
		rd(`RSSD_OFF_STATUS, {30'h0, ex[24], 1'b0}, "status");
		$display("test op %h done", cases[i][47:40]);
	endtask

	// main sequence
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// register reset values
		rd(`RSSD_OFF_WREG, 32'h00000000, "wreg reset");
		rd(`RSSD_OFF_FLAGS, 32'h00000000, "flags reset");
		rd(`RSSD_OFF_IMM, 32'h00000000, "imm reset");
		rd(`RSSD_OFF_ADDR, 32'h00000000, "addr reset");
		rd(`RSSD_OFF_STATUS, 32'h00000000, "status reset");
		$display("test reset values done");
		// unmapped place and read-only status
		host.xfer(1'b0, 12'h01C, 32'h00000000, rv, er);
		chk("unmapped read", 32'h00000000, rv);
		chk("unmapped error", 32'h00000001, {31'h0, er});
		wr(`RSSD_OFF_STATUS, 32'h00000003);
		rd(`RSSD_OFF_STATUS, 32'h00000000, "status after write");
		$display("test map done");
		// every command but the no-op, back to back
		for (int i = 0; i < NC; i++)
			run_case(i);
		// clock enable low stalls a transfer
		ce <= 1'b0;
		fork
			wr(`RSSD_OFF_WREG, 32'h0000005A);
			begin
				repeat (5) @(posedge pclk);
				chk("pready with ce low", 32'h0, {31'h0, pready});
				ce <= 1'b1;
			end
		join
		rd(`RSSD_OFF_WREG, 32'h0000005A, "wreg after stall");
		$display("test clock enable done");
		// leave a skip recorded so the reset has something to clear
		run_case(14);
		// second reset in mid-run
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`RSSD_OFF_WREG, 32'h00000000, "wreg after reset");
		rd(`RSSD_OFF_STATUS, 32'h00000000, "status after reset");
		$display("test second reset done");
		wrap_up();
	end
endmodule
